/* File: shared/ivp_pkg.sv */
// shared constants for the interrupt vector and priority block
package ivp_pkg;

	// ----------------------------------------------------------------
	// routine numbering
	// ----------------------------------------------------------------
	typedef logic [4:0] ivp_num_t;

	localparam int NUM_RANKED = 28;
	localparam ivp_num_t RT_RESET = 5'h00;
	localparam ivp_num_t RT_NMI = 5'h01;
	localparam ivp_num_t RT_EMU = 5'h1d;
	localparam ivp_num_t RT_HIGH_FIRST = 5'h10;
	localparam ivp_num_t RT_HIGH_LAST = 5'h17;
	localparam int GEN_COUNT = 22;
	localparam int VEC_STRIDE_LOG2 = 3;

	// hardware rank order, highest first; rank = index + 1
	localparam ivp_num_t RANK_ORDER [NUM_RANKED] = '{
		5'h00, 5'h1d, 5'h01, 5'h18, 5'h02, 5'h10, 5'h03, 5'h04,
		5'h05, 5'h11, 5'h06, 5'h07, 5'h08, 5'h12, 5'h09, 5'h0a,
		5'h0b, 5'h13, 5'h0c, 5'h0d, 5'h14, 5'h15, 5'h0e, 5'h0f,
		5'h16, 5'h17, 5'h19, 5'h1a};

	// routines 2..26 carry a flag and an enable
	localparam logic [31:0] MASKABLE = 32'h07fffffc;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_FLAGS_LO = 8'h00;
	localparam logic [7:0] REG_FLAGS_HI = 8'h04;
	localparam logic [7:0] REG_ENABLE_LO = 8'h08;
	localparam logic [7:0] REG_ENABLE_HI = 8'h0c;
	localparam logic [7:0] REG_CONTROL = 8'h10;
	localparam logic [7:0] REG_PRI_PAGE = 8'h14;
	localparam logic [7:0] REG_SEC_PAGE = 8'h18;
	localparam logic [7:0] REG_SOFT = 8'h1c;
	localparam logic [7:0] REG_STATUS = 8'h20;

	localparam int CTRL_GMASK_BIT = 0;
	localparam int CTRL_SWRESET_BIT = 1;
	localparam logic GMASK_RESET = 1'b1;
	localparam logic [15:0] PAGE_RESET = 16'h0000;
	localparam int SOFT_PEND_BIT = 8;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ----------------------------------------------------------------
	// delivery sequencer
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_OFFER = 2'h1,
		ST_RETIRE = 2'h3
	} ivp_state_t;

endpackage : ivp_pkg

/* File: shared/ivp_pick_if.sv */
// request set and winner between the controller and its ranker
`timescale 1ns/1ps
interface ivp_pick_if;
	logic [31:0]       req;
	logic              valid;
	ivp_pkg::ivp_num_t num;

	modport ranker (input req, output valid, output num);
	modport user (output req, input valid, input num);
endinterface : ivp_pick_if

/* File: rtl/ivp_ranker.sv */
// fixed-priority ranker over the pending routine set
`timescale 1ns/1ps
module ivp_ranker #(
	parameter int RANKS = ivp_pkg::NUM_RANKED
) (
	// request set and winner
	ivp_pick_if.ranker pick
);

	// ----------------------------------------------------------------
	// ranking
	// ----------------------------------------------------------------
	// scan from lowest rank up so the highest pending one is written last
	always_comb begin
		pick.valid = 1'b0;
		pick.num   = ivp_pkg::RT_RESET;
		for (int i = RANKS - 1; i >= 0; i--) begin
			if (pick.req[ivp_pkg::RANK_ORDER[i]]) begin // [RULE18] [RULE7]
				pick.valid = 1'b1;
				pick.num   = ivp_pkg::RANK_ORDER[i];
			end
		end
	end

endmodule : ivp_ranker

/* File: rtl/ivp_controller.sv */
// interrupt flagging, gating, ranking and vector delivery to the core
`timescale 1ns/1ps

// How it works
// RULE1 - routine 0 is reset, top rank, offset 0
// RULE2 - routine 1 nonmaskable, rank 3, offset 8
// RULE3 - routine 24 bus fault, rank 4, offset C0
// RULE4 - routine 25 log done, rank 27, offset C8
// RULE5 - routine 26 os event, rank 28, offset D0
// RULE6 - routines 30, 31 software only, unranked
// RULE7 - emulation request rank 2; general ranks interleaved
// RULE8 - every maskable source enableable by software
// RULE9 - pins or peripherals drive 22 general requests
// RULE10 - bus fault from system bus or core
// RULE11 - log transfer end raises log done
// RULE12 - breakpoint or watchpoint raises os event
// RULE13 - hardware request sets its pending flag
// RULE14 - set flag alone never causes delivery
// RULE15 - software may enter any maskable routine
// RULE16 - bus fault marks faulting instruction suspect
// RULE17 - routines 16..23 use secondary page
// RULE18 - simultaneous requests served one by one, ranked
// RULE19 - flag holds until taken, cleared, reset
// RULE20 - delivery needs enable 1, global mask 0
// RULE21 - reset, nonmaskables bypass gating, still ranked
module ivp_controller (
	// clock, reset, enable
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// register bus
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// interrupt sources
	input  wire logic [21:0] periphReqPin,
	input  wire logic        nmiPin,
	input  wire logic        emuNmiReq,
	input  wire logic        busFaultSys,
	input  wire logic        busFaultCore,
	input  wire logic        logDoneEvent,
	input  wire logic        breakpointHit,
	input  wire logic        watchpointHit,
	// core pipeline side
	output logic             vecValid,
	output ivp_pkg::ivp_num_t vecNumber,
	output logic [23:0]      vecAddress,
	input  wire logic        vecTaken,
	output logic             faultSuspect
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [21:0]        perA;
	logic [21:0]        perB;
	logic [21:0]        perC;
	logic               nmiA;
	logic               nmiB;
	logic               nmiC;
	logic               emuLast;
	logic [31:0]        flags;
	logic [31:0]        enables;
	logic               gmask;
	logic [15:0]        priPage;
	logic [15:0]        secPage;
	logic               resetPend;
	logic               nmiPend;
	logic               emuPend;
	logic               softPend;
	ivp_pkg::ivp_num_t  softNum;
	logic               vecSoft;
	ivp_pkg::ivp_state_t state;
	logic               wrAccept;
	logic               rdAccept;

	ivp_pick_if pick ();

	ivp_ranker #(
		.RANKS (ivp_pkg::NUM_RANKED)
	) u_ranker (
		.pick (pick)
	);

	// ----------------------------------------------------------------
	// source conditioning
	// ----------------------------------------------------------------
	// pins cross in through two flops; edges are taken off the second
	wire [21:0] perRise  = perB & ~perC; // [RULE9]
	wire        nmiRise  = nmiB & ~nmiC;
	wire        emuRise  = emuNmiReq & ~emuLast;
	wire        busFault = busFaultSys | busFaultCore; // [RULE10]
	wire        osHit    = breakpointHit | watchpointHit; // [RULE12]

	// one set bit per maskable hardware source at its routine position
	wire [31:0] hwSet = {5'h00, osHit, logDoneEvent, busFault, perRise, 2'h0}; // [RULE13] [RULE3] [RULE4] [RULE5] [RULE11]

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			perA    <= 22'h000000;
			perB    <= 22'h000000;
			perC    <= 22'h000000;
			nmiA    <= 1'b0;
			nmiB    <= 1'b0;
			nmiC    <= 1'b0;
			emuLast <= 1'b0;
		end else if (ce) begin
			perA    <= periphReqPin;
			perB    <= perA;
			perC    <= perB;
			nmiA    <= nmiPin;
			nmiB    <= nmiA;
			nmiC    <= nmiB;
			emuLast <= emuNmiReq;
		end
	end

	// ----------------------------------------------------------------
	// register bus decode
	// ----------------------------------------------------------------
	// aw and w are taken together in one beat; one write in flight
	wire        wrFire = wrAccept;
	wire [7:0]  wAddr  = {s_axi_awaddr[7:2], 2'h0};
	wire [7:0]  rAddr  = {s_axi_araddr[7:2], 2'h0};
	wire [31:0] bm     = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
		{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
	wire [31:0] wMasked = s_axi_wdata & bm;

	wire wrFlagLo = wrFire && (wAddr == ivp_pkg::REG_FLAGS_LO);
	wire wrFlagHi = wrFire && (wAddr == ivp_pkg::REG_FLAGS_HI);
	wire wrEnLo   = wrFire && (wAddr == ivp_pkg::REG_ENABLE_LO);
	wire wrEnHi   = wrFire && (wAddr == ivp_pkg::REG_ENABLE_HI);
	wire wrCtrl   = wrFire && (wAddr == ivp_pkg::REG_CONTROL);
	wire wrPri    = wrFire && (wAddr == ivp_pkg::REG_PRI_PAGE);
	wire wrSec    = wrFire && (wAddr == ivp_pkg::REG_SEC_PAGE);
	wire wrSoft   = wrFire && (wAddr == ivp_pkg::REG_SOFT) && s_axi_wstrb[0];
	wire wrHit    = wrFlagLo | wrFlagHi | wrEnLo | wrEnHi | wrCtrl
		| wrPri | wrSec | (wAddr == ivp_pkg::REG_SOFT)
		| (wAddr == ivp_pkg::REG_STATUS);

	// ----------------------------------------------------------------
	// selection and delivery
	// ----------------------------------------------------------------
	// nonmaskable latches join the gated maskable set
	wire [31:0] nonMask = (32'(emuPend) << ivp_pkg::RT_EMU)
		| (32'(nmiPend) << ivp_pkg::RT_NMI) | 32'(resetPend); // [RULE21] [RULE2] [RULE7]
	assign pick.req = (flags & enables & {32{~gmask}}) | nonMask; // [RULE14] [RULE20] [RULE8]

	// a software entry goes ahead of hardware, except a pending reset
	wire               useSoft   = softPend && !resetPend; // [RULE15] [RULE6]
	wire               haveWork  = pick.valid || softPend;
	ivp_pkg::ivp_num_t chosenNum;
	assign chosenNum = useSoft ? softNum : pick.num;

	wire        inHighPage = (chosenNum >= ivp_pkg::RT_HIGH_FIRST)
		&& (chosenNum <= ivp_pkg::RT_HIGH_LAST);
	wire [15:0] pageSel    = inHighPage ? secPage : priPage; // [RULE17]
	wire [23:0] chosenAddr = {pageSel, chosenNum, 3'h0}; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5] [RULE6]

	wire take = (state == ivp_pkg::ST_OFFER) && vecTaken;

	// retire the taken source; software entries only drop their latch
	wire hwTake   = take && !vecSoft;
	wire [31:0] ackClr = hwTake ? ((32'h1 << vecNumber) & ivp_pkg::MASKABLE) : 32'h0; // [RULE19]
	wire clrReset = hwTake && (vecNumber == ivp_pkg::RT_RESET);
	wire clrNmi   = hwTake && (vecNumber == ivp_pkg::RT_NMI);
	wire clrEmu   = hwTake && (vecNumber == ivp_pkg::RT_EMU);

	ivp_pkg::ivp_state_t next_state;
	always_comb begin
		next_state = state;
		unique case (state)
			ivp_pkg::ST_IDLE:   if (haveWork) next_state = ivp_pkg::ST_OFFER; // [RULE18]
			ivp_pkg::ST_OFFER:  if (vecTaken) next_state = ivp_pkg::ST_RETIRE;
			ivp_pkg::ST_RETIRE: next_state = ivp_pkg::ST_IDLE;
			default:            next_state = ivp_pkg::ST_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// next values of the software-visible state
	// ----------------------------------------------------------------
	// set beats clear: an edge landing on a clear stays pending
	wire [31:0] swClr = ({16'h0000, wrFlagLo ? wMasked[15:0] : 16'h0000}
		| {wrFlagHi ? wMasked[15:0] : 16'h0000, 16'h0000});
	wire [31:0] next_flags = ((flags & ~swClr & ~ackClr) | hwSet) & ivp_pkg::MASKABLE; // [RULE13] [RULE19]

	wire [31:0] enMask = ({16'h0000, wrEnLo ? bm[15:0] : 16'h0000}
		| {wrEnHi ? bm[15:0] : 16'h0000, 16'h0000});
	wire [31:0] enData = {s_axi_wdata[15:0], s_axi_wdata[15:0]};
	wire [31:0] next_enables = ((enables & ~enMask) | (enData & enMask)) & ivp_pkg::MASKABLE; // [RULE8]

	wire swReset = wrCtrl && wMasked[ivp_pkg::CTRL_SWRESET_BIT];
	wire next_gmask = (wrCtrl && s_axi_wstrb[0]) ? s_axi_wdata[ivp_pkg::CTRL_GMASK_BIT] : gmask; // [RULE20]
	wire [15:0] next_priPage = wrPri ? ((priPage & ~bm[15:0]) | wMasked[15:0]) : priPage;
	wire [15:0] next_secPage = wrSec ? ((secPage & ~bm[15:0]) | wMasked[15:0]) : secPage;

	wire next_resetPend = swReset | (resetPend & ~clrReset); // [RULE1]
	wire next_nmiPend   = nmiRise | (nmiPend & ~clrNmi); // [RULE2]
	wire next_emuPend   = emuRise | (emuPend & ~clrEmu); // [RULE7]
	// a new software entry is only armed when none is waiting
	wire softArm        = wrSoft && !softPend;
	wire softDrop       = take && vecSoft;
	wire next_softPend  = softArm | (softPend & ~softDrop); // [RULE15]

	// ----------------------------------------------------------------
	// read data mux
	// ----------------------------------------------------------------
	wire [31:0] statusWord = {21'h000000, vecSoft, emuPend, nmiPend,
		resetPend, vecValid, 1'b0, vecNumber};
	wire [31:0] softWord = {23'h000000, softPend, 3'h0, softNum};

	logic [31:0] rdMux;
	logic        rdHit;
	always_comb begin
		rdHit = 1'b1;
		unique case (rAddr)
			ivp_pkg::REG_FLAGS_LO:  rdMux = {16'h0000, flags[15:0]};
			ivp_pkg::REG_FLAGS_HI:  rdMux = {16'h0000, flags[31:16]};
			ivp_pkg::REG_ENABLE_LO: rdMux = {16'h0000, enables[15:0]};
			ivp_pkg::REG_ENABLE_HI: rdMux = {16'h0000, enables[31:16]};
			ivp_pkg::REG_CONTROL:   rdMux = {31'h00000000, gmask};
			ivp_pkg::REG_PRI_PAGE:  rdMux = {16'h0000, priPage};
			ivp_pkg::REG_SEC_PAGE:  rdMux = {16'h0000, secPage};
			ivp_pkg::REG_SOFT:      rdMux = softWord;
			ivp_pkg::REG_STATUS:    rdMux = statusWord;
			default: begin
				rdMux = 32'h00000000;
				rdHit = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// bus handshake flops
	// ----------------------------------------------------------------
	// ready pulses one cycle after both valids, so aw and w pair up
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wrAccept     <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= ivp_pkg::RESP_OKAY;
		end else if (ce) begin
			wrAccept <= !wrAccept && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
			if (wrFire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrHit ? ivp_pkg::RESP_OKAY : ivp_pkg::RESP_DECERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign s_axi_awready = wrAccept;
	assign s_axi_wready  = wrAccept;
	assign s_axi_arready = rdAccept;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdAccept     <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= ivp_pkg::RESP_OKAY;
		end else if (ce) begin
			rdAccept <= !rdAccept && !s_axi_rvalid && s_axi_arvalid;
			if (rdAccept) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdMux;
				s_axi_rresp  <= rdHit ? ivp_pkg::RESP_OKAY : ivp_pkg::RESP_DECERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupt state flops
	// ----------------------------------------------------------------
	// reset leaves the reset routine pending and everything masked
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			flags     <= 32'h00000000;
			enables   <= 32'h00000000;
			gmask     <= ivp_pkg::GMASK_RESET;
			priPage   <= ivp_pkg::PAGE_RESET;
			secPage   <= ivp_pkg::PAGE_RESET;
			resetPend <= 1'b1; // [RULE1]
			nmiPend   <= 1'b0;
			emuPend   <= 1'b0;
			softPend  <= 1'b0;
			softNum   <= ivp_pkg::RT_RESET;
		end else if (ce) begin
			flags     <= next_flags;
			enables   <= next_enables;
			gmask     <= next_gmask;
			priPage   <= next_priPage;
			secPage   <= next_secPage;
			resetPend <= next_resetPend;
			nmiPend   <= next_nmiPend;
			emuPend   <= next_emuPend;
			softPend  <= next_softPend;
			if (softArm) softNum <= s_axi_wdata[4:0];
		end
	end

	// ----------------------------------------------------------------
	// vector offer to the core
	// ----------------------------------------------------------------
	// the offer is frozen until taken; a later higher rank waits its turn
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state      <= ivp_pkg::ST_IDLE;
			vecValid   <= 1'b0;
			vecNumber  <= ivp_pkg::RT_RESET;
			vecAddress <= 24'h000000;
			vecSoft    <= 1'b0;
		end else if (ce) begin
			state    <= next_state;
			vecValid <= (next_state == ivp_pkg::ST_OFFER);
			if (state == ivp_pkg::ST_IDLE && haveWork) begin
				vecNumber  <= chosenNum; // [RULE18]
				vecAddress <= chosenAddr; // [RULE17]
				vecSoft    <= useSoft;
			end
		end
	end

	// ----------------------------------------------------------------
	// bus fault marker
	// ----------------------------------------------------------------
	// tells the pipeline the faulting bundle's results are not to be trusted
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			faultSuspect <= 1'b0;
		end else if (ce) begin
			faultSuspect <= busFault; // [RULE16]
		end
	end

endmodule : ivp_controller

/* File: test/ivp_monitor.sv */
// concurrent checks on the controller's vector and bus ports
`timescale 1ns/1ps
module ivp_monitor (
	// clock and reset
	input wire logic              clock,
	input wire logic              rst_n,
	input wire logic              ce,
	// register bus
	input wire logic              s_axi_awready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_arready,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic [31:0]       s_axi_rdata,
	// sources and core side
	input wire logic              busFaultSys,
	input wire logic              busFaultCore,
	input wire logic              vecValid,
	input wire ivp_pkg::ivp_num_t vecNumber,
	input wire logic [23:0]       vecAddress,
	input wire logic              vecTaken,
	input wire logic              faultSuspect
);
	// ----------------------------------------------------------------
	// one clock domain, so one default clocking and disable
	// ----------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_reset_first: assert property (ce && $rose(rst_n) |=> vecValid && vecNumber == 5'h00 && vecAddress == 24'h0)
		else $error("first offer is not the reset vector");
	a_offer_hold: assert property (vecValid && !vecTaken |=> vecValid && $stable(vecNumber) && $stable(vecAddress))
		else $error("offer changed before it was taken");
	a_retire_gap: assert property (ce && vecValid && vecTaken |=> !vecValid [*2])
		else $error("next offer came too soon");
	a_vector_slot: assert property (vecValid |-> vecAddress[7:0] == {vecNumber, 3'b000})
		else $error("vector offset does not match routine");
	a_fault_mark: assert property (ce && (busFaultSys || busFaultCore) |=> faultSuspect)
		else $error("bus fault not marked");
	a_fault_quiet: assert property (ce && !busFaultSys && !busFaultCore |=> !faultSuspect)
		else $error("suspect mark without a bus fault");
	a_write_answer: assert property (ce && s_axi_awready |=> s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (ce && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");

	// main scenarios reached
	c_offer_taken: cover property (vecValid && vecTaken);
	c_fault: cover property (faultSuspect);
	c_decerr: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
endmodule : ivp_monitor

bind ivp_controller ivp_monitor i_mon (.clock, .rst_n, .ce, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .busFaultSys, .busFaultCore,
	.vecValid, .vecNumber, .vecAddress, .vecTaken, .faultSuspect);

/* File: test/ivp_source_model.sv */
// model of the pins and on-chip event sources
`timescale 1ns/1ps
module ivp_source_model (
	// clock and command; bit n of which raises routine n
	input  wire logic        clock,
	input  wire logic        fire,
	input  wire logic [31:0] which,
	input  wire logic        alt,
	// request lines
	output logic [21:0]      periphReqPin,
	output logic             nmiPin,
	output logic             emuNmiReq,
	output logic             busFaultSys,
	output logic             busFaultCore,
	output logic             logDoneEvent,
	output logic             breakpointHit,
	output logic             watchpointHit
);
	logic [2:0] pinHold = 3'h0;

	// quiet lines from time zero
	initial begin
		{periphReqPin, nmiPin, emuNmiReq, busFaultSys, busFaultCore} = '0;
		{logDoneEvent, breakpointHit, watchpointHit} = '0;
	end

	// pins stay up long enough to cross the two-flop synchroniser
	always @(posedge clock) begin
		if (fire) begin
			periphReqPin <= which[23:2];
			nmiPin <= which[1];
			pinHold <= 3'h5;
		end else if (pinHold != 3'h0) begin
			pinHold <= pinHold - 3'h1;
		end else begin
			periphReqPin <= '0;
			nmiPin <= 1'b0;
		end
		// on-chip events are single-cycle strobes; alt picks which cause
		emuNmiReq <= fire & which[29];
		busFaultSys <= fire & which[24] & ~alt;
		busFaultCore <= fire & which[24] & alt;
		logDoneEvent <= fire & which[25];
		breakpointHit <= fire & which[26] & ~alt;
		watchpointHit <= fire & which[26] & alt;
	end
endmodule : ivp_source_model

/* File: test/tb_top.sv */
// self-checking bench for the interrupt vector and priority controller
`timescale 1ns/1ps
module tb_top;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clock = 1'b0, rst_n = 1'b0, ce = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, vecTaken = 1'b0, fire = 1'b0, alt = 1'b0;
	logic [31:0] which = 32'h0, rd, expSet, en, w;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, vecValid, faultSuspect;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire  [21:0] periphReqPin;
	wire         nmiPin, emuNmiReq, busFaultSys, busFaultCore, logDoneEvent, breakpointHit, watchpointHit;
	wire ivp_pkg::ivp_num_t vecNumber;
	wire  [23:0] vecAddress;
	ivp_pkg::ivp_num_t num;
	logic [23:0] adr;
	logic [15:0] priPage = 16'h0, secPage = 16'h0;
	logic [1:0]  rsp;
	int          mismatches = 0, cmpCount = 0, seed = 22894, r, i, k;
	// hardware rank order, highest first
	int rk [28] = '{0, 29, 1, 24, 2, 16, 3, 4, 5, 17, 6, 7, 8, 18, 9, 10, 11, 19, 12, 13, 20, 21, 14, 15, 22, 23, 25, 26};

	ivp_controller i_dut (.clock, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periphReqPin,
		.nmiPin, .emuNmiReq, .busFaultSys, .busFaultCore, .logDoneEvent, .breakpointHit, .watchpointHit,
		.vecValid, .vecNumber, .vecAddress, .vecTaken, .faultSuspect);
	ivp_source_model i_src (.clock, .fire, .which, .alt, .periphReqPin, .nmiPin, .emuNmiReq, .busFaultSys,
		.busFaultCore, .logDoneEvent, .breakpointHit, .watchpointHit);

	always #50 clock = ~clock;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [23:0] expAdr(input int n);
		return {(n >= 16 && n <= 23) ? secPage : priPage, n[4:0], 3'b000};
	endfunction : expAdr

	// ready raised late on purpose so the response has to stand
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		// no local limit: only the hang guard may end this wait
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b1;
		@(posedge clock);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clock);
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b1;
		@(posedge clock);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clock);
	endtask : rdr

	// wait for an offer, check it and hand it back taken
	task automatic offer(input int n);
		do @(posedge clock); while (!vecValid);
		num = vecNumber;
		adr = vecAddress;
		vecTaken <= 1'b1;
		@(posedge clock);
		vecTaken <= 1'b0;
		chk(num, n);
		chk(adr, expAdr(n));
	endtask : offer

	task automatic raise(input logic [31:0] v);
		which <= v;
		alt <= 1'($random(seed));
		fire <= 1'b1;
		@(posedge clock);
		fire <= 1'b0;
		repeat (12) @(posedge clock);
	endtask : raise

	task automatic setEn(input logic [31:0] v);
		wr(8'h08, {16'h0, v[15:0]});
		wr(8'h0c, {21'h0, v[26:16]});
	endtask : setEn

	task automatic chkFlags(input logic [31:0] v);
		rdr(8'h00);
		chk(rd, {16'h0, v[15:2], 2'b00});
		rdr(8'h04);
		chk(rd, {21'h0, v[26:16]});
	endtask : chkFlags

	task automatic final_report();
		$display("compares %0d mismatches %0d", cmpCount, mismatches);
		if (mismatches == 0 && cmpCount > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : final_report

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		offer(0);
		rdr(8'h10);
		chk(rd, 32'h1);
		rdr(8'h08);
		chk(rd, 32'h0);
		priPage = 16'($random(seed));
		secPage = 16'($random(seed));
		wr(8'h14, {16'h0, priPage});
		wr(8'h18, {16'h0, secPage});
		$display("test reset_and_pages done");
		// flag alone, then enable without global unmask, must not deliver
		r = 2 + {$random(seed)} % 22;
		en = 32'h1 << r;
		raise(en);
		chkFlags(en);
		chk(vecValid, 1'b0);
		setEn(en);
		repeat (12) @(posedge clock);
		chk(vecValid, 1'b0);
		wr(8'h10, 32'h0);
		offer(r);
		chkFlags(32'h0);
		$display("test gating done");
		// many requests at once, first pass is every source enabled
		for (k = 0; k < 6; k++) begin
			wr(8'h10, 32'h1);
			w = (k == 0) ? 32'h27fffffe : 32'($random(seed)) & 32'h27fffffe;
			en = (k == 0) ? 32'hffffffff : 32'($random(seed));
			setEn(en);
			raise(w);
			wr(8'h10, 32'h0);
			expSet = w & ((en & 32'h07fffffc) | 32'h20000002);
			for (i = 0; i < 28; i++) if (expSet[rk[i]]) offer(rk[i]);
			chkFlags(w & ~en & 32'h07fffffc);
			wr(8'h00, 32'hffff);
			wr(8'h04, 32'h7ff);
			chkFlags(32'h0);
		end
		$display("test ranking done");
		// software entries, software-only routines among them
		setEn(32'hffffffff);
		for (k = 0; k < 4; k++) begin
			r = (k == 0) ? 30 : (k == 1) ? 31 : (k == 2) ? 1 : 2 + {$random(seed)} % 25;
			wr(8'h1c, r);
			offer(r);
		end
		$display("test software_entry done");
		// software reset re-pends routine 0; a frozen block must ignore the take
		wr(8'h10, 32'h2);
		ce <= 1'b0;
		vecTaken <= 1'b1;
		repeat (4) @(posedge clock);
		chk(vecValid, 1'b1);
		ce <= 1'b1;
		vecTaken <= 1'b0;
		offer(0);
		$display("test soft_reset_freeze done");
		// unmapped places answer with a decode error
		rdr(8'h24);
		chk(rd, 32'h0);
		chk(rsp, 2'h3);
		wr(8'h30, 32'h1);
		chk(rsp, 2'h3);
		$display("test unmapped done");
		final_report();
	end

	// hang guard, far beyond the thousand or so cycles the tests need
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		final_report();
	end
endmodule : tb_top
